// File: logic/apcr_bank.sv
// apcr_bank: audio path control register bank behind the two-wire control interface
// assumes the serial interface hands over whole bytes as one-cycle strobes in the clk_i domain
// and that reset_i is driven by the analog supply power-on reset
//
// Functional notes
// - right mic bit7 picks differential or single-ended
// - preamp code 00/01/10 gives 30/36/42 dB
// - analog volumes: 1.5 dB steps, -40.5 to +6
// - left mic bit7 set disables mic supply
// - left mic bit6 set mutes microphone input
// - gated gain registers clear when block disabled
// - writes to disabled line, playback, record gain registers ignored
// - all registers clear on supply power-on reset
// - right line bit7 picks high-quality line input
// - active-low mute bits pass signal when set
// - left line bit6 picks stereo or dual mono
// - record source: mic, line1, line2, mixer
// - record rate: frame/2, frame/4, or undivided
// - interface bit7 picks external master clock pin
// - interface bit6 loops record data to playback
// - interface bit5 enables digital attenuation
// - attenuation 1.5 dB steps, -48 to -1.5
// - power bits enable record, playback, stage, line, mic
// - block bits disable bias, mixer, limiter
// - fade step 2/4/8 ms or fading off
// - mic supply ratio 20/17, 20/22, 20/27, 20/32
// - mixer routing bits for mic, record, line
`default_nettype none

`include "apcr_map.svh"

module apcr_bank (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output apcr_pkg::apcr_regs_s regs_o,
  output apcr_pkg::apcr_ctrl_s ctrl_o
);

  apcr_pkg::apcr_state_s st_ff;
  apcr_pkg::apcr_state_s nxt_st;

  // ========================================================================
  // helpers
  function automatic logic signed [7:0] half_db(input logic [4:0] code, input logic [7:0] base);
    half_db = $signed(8'({3'h0, code} * `APCR_STEP_HALF_DB) + base);
  endfunction : half_db

  function automatic logic [7:0] masked(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] mask);
    masked = (new_v & mask) | (old_v & ~mask);
  endfunction : masked

  function automatic logic [7:0] read_byte(input apcr_pkg::apcr_regs_s r, input logic [7:0] a);
    if (a == `APCR_OFS_RIGHT_MIC)
      read_byte = r.right_microphone_gain;
    else if (a == `APCR_OFS_LEFT_MIC)
      read_byte = r.left_microphone_gain;
    else if (a == `APCR_OFS_RIGHT_LINE)
      read_byte = r.right_line_input_gain;
    else if (a == `APCR_OFS_LEFT_LINE)
      read_byte = r.left_line_input_gain;
    else if (a == `APCR_OFS_LEFT_PLAY)
      read_byte = r.left_playback_level;
    else if (a == `APCR_OFS_RIGHT_PLAY)
      read_byte = r.right_playback_level;
    else if (a == `APCR_OFS_LEFT_REC)
      read_byte = r.left_record_level;
    else if (a == `APCR_OFS_RIGHT_REC)
      read_byte = r.right_record_level;
    else if (a == `APCR_OFS_DIG_IF)
      read_byte = r.digital_audio_interface_ctrl;
    else if (a == `APCR_OFS_POWER)
      read_byte = r.audio_power_enables;
    else if (a == `APCR_OFS_BLOCK)
      read_byte = r.audio_block_controls;
    else if (a == `APCR_OFS_MIXER)
      read_byte = r.mixer_routing_controls;
    else
      read_byte = 8'h00;
  endfunction : read_byte

  // ========================================================================
  // next state
  always_comb
  begin
    logic line_on;
    logic play_on;
    logic rec_on;
    apcr_pkg::apcr_regs_s r;
    line_on = st_ff.regs.audio_power_enables[`APCR_PWR_LINE];
    play_on = st_ff.regs.audio_power_enables[`APCR_PWR_DAC];
    rec_on = st_ff.regs.audio_power_enables[`APCR_PWR_ADC];
    nxt_st = st_ff;
    r = st_ff.regs;

    // masks keep reserved bits at zero whatever is written
    if (wr_en_i)
    begin
      if (wr_addr_i == `APCR_OFS_RIGHT_MIC)
        r.right_microphone_gain = masked(r.right_microphone_gain, wr_data_i, `APCR_MASK_RIGHT_MIC);
      else if (wr_addr_i == `APCR_OFS_LEFT_MIC)
        r.left_microphone_gain = masked(r.left_microphone_gain, wr_data_i, `APCR_MASK_LEFT_MIC);
      else if (wr_addr_i == `APCR_OFS_RIGHT_LINE && line_on)
        r.right_line_input_gain = masked(r.right_line_input_gain, wr_data_i, `APCR_MASK_RIGHT_LINE);
      else if (wr_addr_i == `APCR_OFS_LEFT_LINE && line_on)
        r.left_line_input_gain = masked(r.left_line_input_gain, wr_data_i, `APCR_MASK_LEFT_LINE);
      else if (wr_addr_i == `APCR_OFS_LEFT_PLAY && play_on)
        r.left_playback_level = masked(r.left_playback_level, wr_data_i, `APCR_MASK_LEFT_PLAY);
      else if (wr_addr_i == `APCR_OFS_RIGHT_PLAY && play_on)
        r.right_playback_level = masked(r.right_playback_level, wr_data_i, `APCR_MASK_RIGHT_PLAY);
      else if (wr_addr_i == `APCR_OFS_LEFT_REC && rec_on)
        r.left_record_level = masked(r.left_record_level, wr_data_i, `APCR_MASK_LEFT_REC);
      else if (wr_addr_i == `APCR_OFS_RIGHT_REC && rec_on)
        r.right_record_level = masked(r.right_record_level, wr_data_i, `APCR_MASK_RIGHT_REC);
      else if (wr_addr_i == `APCR_OFS_DIG_IF)
        r.digital_audio_interface_ctrl = masked(r.digital_audio_interface_ctrl, wr_data_i, `APCR_MASK_DIG_IF);
      else if (wr_addr_i == `APCR_OFS_POWER)
        r.audio_power_enables = masked(r.audio_power_enables, wr_data_i, `APCR_MASK_POWER);
      else if (wr_addr_i == `APCR_OFS_BLOCK)
        r.audio_block_controls = masked(r.audio_block_controls, wr_data_i, `APCR_MASK_BLOCK);
      else if (wr_addr_i == `APCR_OFS_MIXER)
        r.mixer_routing_controls = masked(r.mixer_routing_controls, wr_data_i, `APCR_MASK_MIXER);
    end

    // disabled blocks are held at default; the clear lands one cycle after the enable drops
    if (!line_on)
    begin
      r.right_line_input_gain = `APCR_RESET_VALUE;
      r.left_line_input_gain = `APCR_RESET_VALUE;
    end
    if (!play_on)
    begin
      r.left_playback_level = `APCR_RESET_VALUE;
      r.right_playback_level = `APCR_RESET_VALUE;
    end
    if (!rec_on)
    begin
      r.left_record_level = `APCR_RESET_VALUE;
      r.right_record_level = `APCR_RESET_VALUE;
    end
    nxt_st.regs = r;

    // reads see the image before any same-cycle write
    if (rd_en_i)
      nxt_st.rd_data = read_byte(st_ff.regs, rd_addr_i);

    // decode from the new image so fields and controls move on the same edge
    nxt_st.ctrl.mic_single_ended = r.right_microphone_gain[7];
    case (r.right_microphone_gain[6:5])
      2'h0: nxt_st.ctrl.preamp_gain_db = `APCR_PREAMP_DB_0;
      2'h1: nxt_st.ctrl.preamp_gain_db = `APCR_PREAMP_DB_1;
      2'h2: nxt_st.ctrl.preamp_gain_db = `APCR_PREAMP_DB_2;
      // reserved code: hold the lowest gain rather than an undefined one
      default: nxt_st.ctrl.preamp_gain_db = `APCR_PREAMP_DB_0;
    endcase
    nxt_st.ctrl.right_microphone_level = half_db(r.right_microphone_gain[4:0], `APCR_ANALOG_BASE);
    nxt_st.ctrl.left_microphone_level = half_db(r.left_microphone_gain[4:0], `APCR_ANALOG_BASE);
    nxt_st.ctrl.microphone_supply_disable = r.left_microphone_gain[7];
    nxt_st.ctrl.mic_mute = r.left_microphone_gain[6];
    nxt_st.ctrl.line_input_quality = r.right_line_input_gain[7];
    nxt_st.ctrl.line_input_stereo_or_mono = r.left_line_input_gain[6];
    nxt_st.ctrl.right_line_level = half_db(r.right_line_input_gain[4:0], `APCR_ANALOG_BASE);
    nxt_st.ctrl.left_line_level = half_db(r.left_line_input_gain[4:0], `APCR_ANALOG_BASE);
    nxt_st.ctrl.right_line_pass = r.right_line_input_gain[5];
    nxt_st.ctrl.left_line_pass = r.left_line_input_gain[5];
    nxt_st.ctrl.left_playback_pass = r.left_playback_level[5];
    nxt_st.ctrl.left_record_pass = r.left_record_level[5];
    nxt_st.ctrl.record_source_select = apcr_pkg::apcr_src_e'(r.right_record_level[7:6]);
    case (r.left_record_level[7:6])
      2'h0: nxt_st.ctrl.record_rate_divider = `APCR_RATE_DIV_0;
      2'h1: nxt_st.ctrl.record_rate_divider = `APCR_RATE_DIV_1;
      default: nxt_st.ctrl.record_rate_divider = `APCR_RATE_DIV_2;
    endcase
    nxt_st.ctrl.mclk_from_pin = r.digital_audio_interface_ctrl[7];
    nxt_st.ctrl.record_loopback = r.digital_audio_interface_ctrl[6];
    nxt_st.ctrl.digital_attenuation_enable = r.digital_audio_interface_ctrl[5];
    // bypass shows as unity gain on the serial input path
    if (r.digital_audio_interface_ctrl[5])
      nxt_st.ctrl.serial_audio_input_gain = half_db(r.digital_audio_interface_ctrl[4:0], `APCR_ATTEN_BASE);
    else
      nxt_st.ctrl.serial_audio_input_gain = 8'sh00;
    nxt_st.ctrl.power_record = r.audio_power_enables[`APCR_PWR_ADC];
    nxt_st.ctrl.power_playback = r.audio_power_enables[`APCR_PWR_DAC];
    nxt_st.ctrl.playback_gain_stage_power = r.audio_power_enables[`APCR_PWR_GAIN_STAGE];
    nxt_st.ctrl.power_line = r.audio_power_enables[`APCR_PWR_LINE];
    nxt_st.ctrl.power_mic = r.audio_power_enables[`APCR_PWR_MIC];
    nxt_st.ctrl.bias_disable = r.audio_block_controls[7];
    nxt_st.ctrl.summing_stage_power_down = r.audio_block_controls[6];
    nxt_st.ctrl.summing_limiter_disable = r.audio_block_controls[5];
    nxt_st.ctrl.fade_off = (r.audio_block_controls[3:2] == 2'h3);
    case (r.audio_block_controls[3:2])
      2'h0: nxt_st.ctrl.fade_step_ms = `APCR_FADE_MS_0;
      2'h1: nxt_st.ctrl.fade_step_ms = `APCR_FADE_MS_1;
      2'h2: nxt_st.ctrl.fade_step_ms = `APCR_FADE_MS_2;
      default: nxt_st.ctrl.fade_step_ms = 4'h0;
    endcase
    nxt_st.ctrl.microphone_supply_ratio = r.audio_block_controls[1:0];
    case (r.audio_block_controls[1:0])
      2'h0: nxt_st.ctrl.supply_ratio_denominator = `APCR_RATIO_DEN_0;
      2'h1: nxt_st.ctrl.supply_ratio_denominator = `APCR_RATIO_DEN_1;
      2'h2: nxt_st.ctrl.supply_ratio_denominator = `APCR_RATIO_DEN_2;
      default: nxt_st.ctrl.supply_ratio_denominator = `APCR_RATIO_DEN_3;
    endcase
    nxt_st.ctrl.microphone_to_summer_disable = r.mixer_routing_controls[6];
    nxt_st.ctrl.record_to_summer_enable = r.mixer_routing_controls[4];
    nxt_st.ctrl.line_to_summer_disable = r.mixer_routing_controls[3];
  end

  // ========================================================================
  // state register; reset loads the decode of the all-zero image, not bare zeros,
  // so the analog path never sees 0 dB or a zero divider while the supply comes up
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_ff <= '0;
      st_ff.ctrl.preamp_gain_db <= `APCR_PREAMP_DB_0;
      st_ff.ctrl.right_microphone_level <= $signed(`APCR_ANALOG_BASE);
      st_ff.ctrl.left_microphone_level <= $signed(`APCR_ANALOG_BASE);
      st_ff.ctrl.right_line_level <= $signed(`APCR_ANALOG_BASE);
      st_ff.ctrl.left_line_level <= $signed(`APCR_ANALOG_BASE);
      st_ff.ctrl.record_rate_divider <= `APCR_RATE_DIV_0;
      st_ff.ctrl.fade_step_ms <= `APCR_FADE_MS_0;
      st_ff.ctrl.supply_ratio_denominator <= `APCR_RATIO_DEN_0;
    end
    else
      st_ff <= nxt_st;
  end

  assign rd_data_o = st_ff.rd_data;
  assign regs_o = st_ff.regs;
  assign ctrl_o = st_ff.ctrl;

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_line_write_off;
    wr_en_i && wr_addr_i == `APCR_OFS_RIGHT_LINE && !st_ff.regs.audio_power_enables[`APCR_PWR_LINE];
  endsequence

  sequence s_record_drop;
    $fell(st_ff.regs.audio_power_enables[`APCR_PWR_ADC]);
  endsequence

  a_write_lands: assert property (
    wr_en_i && wr_addr_i == `APCR_OFS_LEFT_MIC |=>
      regs_o.left_microphone_gain == ($past(wr_data_i) & `APCR_MASK_LEFT_MIC) && ctrl_o.mic_mute == $past(wr_data_i[6]))
    else $error("left mic write did not land next cycle");

  a_gated_write_ignored: assert property (s_line_write_off |=> regs_o.right_line_input_gain == 8'h00)
    else $error("write to disabled line register took effect");

  a_gated_clear: assert property (s_record_drop |=> regs_o.left_record_level == 8'h00 &&
                                  regs_o.right_record_level == 8'h00)
    else $error("record gain registers not cleared after disable");

  a_reserved_zero: assert property (
    regs_o.left_microphone_gain[5] == 1'b0 && regs_o.right_playback_level[7:5] == 3'h0 &&
    regs_o.audio_power_enables[4:3] == 2'h0 && regs_o.mixer_routing_controls[7] == 1'b0)
    else $error("reserved bit holds a one");

  a_preamp_gain: assert property (
    regs_o.right_microphone_gain[6:5] == 2'h1 |-> ctrl_o.preamp_gain_db == 6'h24)
    else $error("preamp code 01 not 36 dB");

  a_level_step: assert property (
    ctrl_o.left_line_level == $signed(8'({3'h0, regs_o.left_line_input_gain[4:0]} * 8'h03) - 8'h51))
    else $error("line level off the 1.5 dB grid");

  a_rate_divider: assert property (
    regs_o.left_record_level[7] |-> ctrl_o.record_rate_divider == 3'h1)
    else $error("record rate not undivided for codes 10 and 11");

  a_atten_bypass: assert property (
    !regs_o.digital_audio_interface_ctrl[5] |-> ctrl_o.serial_audio_input_gain == 8'sh00)
    else $error("attenuation applied while bypassed");

  a_fade_off: assert property (
    ctrl_o.fade_off |-> ctrl_o.fade_step_ms == 4'h0 && regs_o.audio_block_controls[3:2] == 2'h3)
    else $error("fade off without code 11");

  a_read_back: assert property (
    rd_en_i && rd_addr_i == `APCR_OFS_POWER |=> rd_data_o == $past(regs_o.audio_power_enables))
    else $error("power register read back wrong");

endmodule : apcr_bank

`default_nettype wire

// File: logic/apcr_map.svh
// apcr_map.svh: offsets, masks, reset values and decode figures of the audio control register bank
// assumes it is included by bare name by the design file, the host model and the bench
`ifndef APCR_MAP_SVH
`define APCR_MAP_SVH

// ==========================================================================
// register offsets on the serial control interface
`define APCR_OFS_RIGHT_MIC 8'h06
`define APCR_OFS_LEFT_MIC 8'h07
`define APCR_OFS_RIGHT_LINE 8'h0A
`define APCR_OFS_LEFT_LINE 8'h0B
`define APCR_OFS_LEFT_PLAY 8'h0C
`define APCR_OFS_RIGHT_PLAY 8'h0E
`define APCR_OFS_LEFT_REC 8'h0F
`define APCR_OFS_RIGHT_REC 8'h10
`define APCR_OFS_DIG_IF 8'h12
`define APCR_OFS_POWER 8'h14
`define APCR_OFS_BLOCK 8'h15
`define APCR_OFS_MIXER 8'h16

// ==========================================================================
// writable bits; everything outside the mask is reserved
`define APCR_MASK_RIGHT_MIC 8'hFF
`define APCR_MASK_LEFT_MIC 8'hDF
`define APCR_MASK_RIGHT_LINE 8'hFF
`define APCR_MASK_LEFT_LINE 8'hFF
`define APCR_MASK_LEFT_PLAY 8'h3F
`define APCR_MASK_RIGHT_PLAY 8'h1F
`define APCR_MASK_LEFT_REC 8'hFF
`define APCR_MASK_RIGHT_REC 8'hDF
`define APCR_MASK_DIG_IF 8'hFF
`define APCR_MASK_POWER 8'hE5
`define APCR_MASK_BLOCK 8'hFF
`define APCR_MASK_MIXER 8'h5F

`define APCR_RESET_VALUE 8'h00

// ==========================================================================
// power-enable bit positions
`define APCR_PWR_ADC 7
`define APCR_PWR_DAC 6
`define APCR_PWR_GAIN_STAGE 5
`define APCR_PWR_LINE 2
`define APCR_PWR_MIC 0

// ==========================================================================
// decode figures; levels are in half-dB units, two's complement
`define APCR_ANALOG_BASE 8'hAF
`define APCR_ATTEN_BASE 8'hA0
`define APCR_STEP_HALF_DB 8'h03
`define APCR_PREAMP_DB_0 6'h1E
`define APCR_PREAMP_DB_1 6'h24
`define APCR_PREAMP_DB_2 6'h2A
`define APCR_FADE_MS_0 4'h2
`define APCR_FADE_MS_1 4'h4
`define APCR_FADE_MS_2 4'h8
`define APCR_RATE_DIV_0 3'h2
`define APCR_RATE_DIV_1 3'h4
`define APCR_RATE_DIV_2 3'h1
`define APCR_RATIO_DEN_0 6'h11
`define APCR_RATIO_DEN_1 6'h16
`define APCR_RATIO_DEN_2 6'h1B
`define APCR_RATIO_DEN_3 6'h20

`endif

// File: logic/apcr_pkg.sv
// apcr_pkg: types of the audio control register bank
// assumes apcr_map.svh is on the include path
`default_nettype none

package apcr_pkg;

  // ========================================================================
  // register image
  typedef struct packed {
    logic [7:0] right_microphone_gain;
    logic [7:0] left_microphone_gain;
    logic [7:0] right_line_input_gain;
    logic [7:0] left_line_input_gain;
    logic [7:0] left_playback_level;
    logic [7:0] right_playback_level;
    logic [7:0] left_record_level;
    logic [7:0] right_record_level;
    logic [7:0] digital_audio_interface_ctrl;
    logic [7:0] audio_power_enables;
    logic [7:0] audio_block_controls;
    logic [7:0] mixer_routing_controls;
  } apcr_regs_s;

  typedef enum logic [1:0] {
    APCR_SRC_MIC,
    APCR_SRC_LINE1,
    APCR_SRC_LINE2,
    APCR_SRC_MIXER
  } apcr_src_e;

  // ========================================================================
  // decoded controls for the analog and digital audio paths
  typedef struct packed {
    logic mic_single_ended;
    logic [5:0] preamp_gain_db;
    logic signed [7:0] right_microphone_level;
    logic signed [7:0] left_microphone_level;
    logic microphone_supply_disable;
    logic mic_mute;
    logic line_input_quality;
    logic line_input_stereo_or_mono;
    logic signed [7:0] right_line_level;
    logic signed [7:0] left_line_level;
    logic right_line_pass;
    logic left_line_pass;
    logic left_playback_pass;
    logic left_record_pass;
    apcr_src_e record_source_select;
    logic [2:0] record_rate_divider;
    logic mclk_from_pin;
    logic record_loopback;
    logic digital_attenuation_enable;
    logic signed [7:0] serial_audio_input_gain;
    logic power_record;
    logic power_playback;
    logic playback_gain_stage_power;
    logic power_line;
    logic power_mic;
    logic bias_disable;
    logic summing_stage_power_down;
    logic summing_limiter_disable;
    logic fade_off;
    logic [3:0] fade_step_ms;
    logic [1:0] microphone_supply_ratio;
    logic [5:0] supply_ratio_denominator;
    logic microphone_to_summer_disable;
    logic record_to_summer_enable;
    logic line_to_summer_disable;
  } apcr_ctrl_s;

  typedef struct packed {
    apcr_regs_s regs;
    apcr_ctrl_s ctrl;
    logic [7:0] rd_data;
  } apcr_state_s;

endpackage : apcr_pkg

`default_nettype wire

// File: tb/apcr_host.sv
// apcr_host: host-side model that issues byte write and read strobes to the audio control bank
// assumes clk_i is the bank clock; all strobes are driven on falling edges
`default_nettype none

`include "apcr_map.svh"

module apcr_host (
  input wire logic clk_i,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic rd_en_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 8'h00;
    rd_addr_o = 8'h00;
  end

  // ==========================================================================
  // bus cycles
  // released qualifiers are inverted so a stale value never passes as valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    @(negedge clk_i);
    rd_en_o = 1'b0;
    rd_addr_o = ~a;
    d = rd_data_i;
  endtask : rd

endmodule : apcr_host

`default_nettype wire

// File: tb/test_audio_path_control_registers.sv
// test_audio_path_control_registers: self-checking bench of the audio control register bank
// assumes apcr_map.svh on the include path and apcr_host as the strobe driver
`default_nettype none

`include "apcr_map.svh"

module test_audio_path_control_registers;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i;
  logic reset_i;
  logic wr_en;
  logic rd_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  apcr_pkg::apcr_regs_s regs;
  apcr_pkg::apcr_ctrl_s c;
  logic [7:0] exp [0:31];
  logic [7:0] ofs [0:12];
  int err_count;
  int n_tests;
  int cyc;

  apcr_bank apcr_bank_inst (.clk_i(clk_i), .reset_i(reset_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
    .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .regs_o(regs),
    .ctrl_o(c));
  apcr_host apcr_host_inst (.clk_i(clk_i), .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .rd_en_o(rd_en), .rd_addr_o(rd_addr), .rd_data_i(rd_data));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================================================
  // reference model
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      `APCR_OFS_LEFT_MIC: return 8'hDF;
      `APCR_OFS_LEFT_PLAY: return 8'h3F;
      `APCR_OFS_RIGHT_PLAY: return 8'h1F;
      `APCR_OFS_RIGHT_REC: return 8'hDF;
      `APCR_OFS_POWER: return 8'hE5;
      `APCR_OFS_MIXER: return 8'h5F;
      `APCR_OFS_RIGHT_MIC, `APCR_OFS_RIGHT_LINE, `APCR_OFS_LEFT_LINE, `APCR_OFS_LEFT_REC,
      `APCR_OFS_DIG_IF, `APCR_OFS_BLOCK: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction : mask_of

  function automatic int gate_of(input logic [7:0] a);
    case (a)
      `APCR_OFS_RIGHT_LINE, `APCR_OFS_LEFT_LINE: return 2;
      `APCR_OFS_LEFT_PLAY, `APCR_OFS_RIGHT_PLAY: return 6;
      `APCR_OFS_LEFT_REC, `APCR_OFS_RIGHT_REC: return 7;
      default: return -1;
    endcase
  endfunction : gate_of

  // half-dB level: 1.5 dB per code step above the floor
  function automatic logic [7:0] lvl(input logic [4:0] code, input int floor_hdb);
    return 8'(3 * int'(code) - floor_hdb);
  endfunction : lvl

  // ==========================================================================
  // checks and bus helpers
  task automatic chk(input string what, input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    int g;
    g = gate_of(a);
    apcr_host_inst.wr(a, d);
    if (g < 0 || exp[`APCR_OFS_POWER][g]) exp[a[4:0]] = d & mask_of(a);
    if (a == `APCR_OFS_POWER)
      for (int i = 0; i < 32; i++)
        if (gate_of(8'(i)) >= 0 && !exp[`APCR_OFS_POWER][gate_of(8'(i))]) exp[i] = 8'h00;
  endtask : put

  task automatic get(input logic [7:0] a);
    logic [7:0] v;
    apcr_host_inst.rd(a, v);
    chk("read", {56'h0, v}, {56'h0, exp[a[4:0]]});
  endtask : get

  task automatic chk_ctrl();
    logic [7:0] m;
    logic [7:0] n;
    logic [7:0] d;
    logic [7:0] b;
    logic [7:0] x;
    logic [7:0] p;
    m = exp[`APCR_OFS_RIGHT_MIC];
    n = exp[`APCR_OFS_LEFT_MIC];
    d = exp[`APCR_OFS_DIG_IF];
    b = exp[`APCR_OFS_BLOCK];
    x = exp[`APCR_OFS_MIXER];
    p = exp[`APCR_OFS_POWER];
    chk("mic", {c.mic_single_ended, c.preamp_gain_db, c.right_microphone_level, c.left_microphone_level,
      c.microphone_supply_disable, c.mic_mute}, {m[7], (m[6:5] == 2'h1) ? 6'd36 : (m[6:5] == 2'h2) ? 6'd42 : 6'd30,
      lvl(m[4:0], 81), lvl(n[4:0], 81), n[7], n[6]});
    chk("line", {c.line_input_quality, c.line_input_stereo_or_mono, c.right_line_level, c.left_line_level,
      c.right_line_pass, c.left_line_pass, c.left_playback_pass, c.left_record_pass},
      {exp[10][7], exp[11][6], lvl(exp[10][4:0], 81), lvl(exp[11][4:0], 81), exp[10][5], exp[11][5],
      exp[12][5], exp[15][5]});
    chk("digital", {c.record_source_select, c.record_rate_divider, c.mclk_from_pin, c.record_loopback,
      c.digital_attenuation_enable, c.serial_audio_input_gain}, {exp[16][7:6],
      (exp[15][7:6] == 2'h0) ? 3'd2 : (exp[15][7:6] == 2'h1) ? 3'd4 : 3'd1, d[7:5],
      d[5] ? lvl(d[4:0], 96) : 8'h00});
    chk("settings", {c.power_record, c.power_playback, c.playback_gain_stage_power, c.power_line, c.power_mic,
      c.bias_disable, c.summing_stage_power_down, c.summing_limiter_disable, c.fade_off, c.fade_step_ms,
      c.microphone_supply_ratio, c.supply_ratio_denominator, c.microphone_to_summer_disable,
      c.record_to_summer_enable, c.line_to_summer_disable}, {p[7:5], p[2], p[0], b[7:5], b[3:2] == 2'h3,
      (b[3:2] == 2'h3) ? 4'd0 : 4'(2 << b[3:2]), b[1:0], 6'(17 + 5 * int'(b[1:0])), x[6],
      x[4:3]});
  endtask : chk_ctrl

  task automatic do_reset();
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 32; i++) exp[i] = 8'h00;
    for (int k = 0; k < 13; k++) get(ofs[k]);
    chk_ctrl();
  endtask : do_reset

  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_count++;
      wrap_up();
    end
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    logic [7:0] a;
    logic [7:0] d;
    reset_i = 1'b1;
    ofs = '{8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h12, 8'h14, 8'h15, 8'h16, 8'h13};
    void'($urandom(32'h18be));
    do_reset();
    put(`APCR_OFS_LEFT_MIC, 8'hE0);
    chk("latency", {56'h0, regs.left_microphone_gain}, 64'hC0);
    chk("mute", {62'h0, c.microphone_supply_disable, c.mic_mute}, 64'h3);
    put(`APCR_OFS_RIGHT_LINE, 8'hAB);
    get(`APCR_OFS_RIGHT_LINE);
    put(`APCR_OFS_POWER, 8'hFF);
    put(`APCR_OFS_RIGHT_LINE, 8'hAB);
    put(`APCR_OFS_POWER, 8'hC1);
    get(`APCR_OFS_RIGHT_LINE);
    for (int i = 0; i < 4; i++)
    begin
      put(`APCR_OFS_BLOCK, {4'h0, 2'(i), 2'(i)});
      if (i < 3) put(`APCR_OFS_RIGHT_MIC, {1'b1, 2'(i), 5'h1F});
      chk_ctrl();
    end
    for (int j = 0; j < 300; j++)
    begin
      a = ofs[$urandom_range(12)];
      d = 8'($urandom);
      if (a == `APCR_OFS_RIGHT_MIC && d[6:5] == 2'h3) d[6] = 1'b0;
      put(a, d);
      get(ofs[$urandom_range(12)]);
      chk_ctrl();
      if (j == 150) do_reset();
    end
    wrap_up();
  end

endmodule : test_audio_path_control_registers

`default_nettype wire
